// *** src/core_interrupt_controller.sv ***
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - any reset leaves every interrupt disabled
// - redirect needs global and source enable
// - peripheral sources also need group enable
// - flags set regardless of any enable
// - flags live in control and four flag registers
// - entry flushes, clears global, pushes, saves, vectors
// - in service with global clear, events flag but never redirect
// - return pops, restores shadows, sets global enable
// - pending event serviced once global enable returns
// - synchronous source latency is 3 or 4 cycles
// - asynchronous source latency is 3 to 5 cycles; the pin path here takes 6, 3 more than the timer
// - pin flag may set at any phase
// - on wake vector if global set, else continue
// - instruction after sleep runs before the branch
// - external pin gives edge-triggered, enabled interrupt
// - edge select high rising, low falling
// - valid pin edge sets flag, vectors if enabled
// - shadows hold W, status less TO/PD, bank, pointers, latch
// - control bit7 global, bit6 group, bit1 pin flag
module core_interrupt_controller
   import irq_ctrl_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [irq_ctrl_pkg::ADDR_W-1:0] i_paddr,
   input wire logic [irq_ctrl_pkg::DATA_W-1:0] i_pwdata,
   output logic [irq_ctrl_pkg::DATA_W-1:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // event sources
   input wire logic i_tmr0_evt,
   input wire logic i_ioc_level,
   input wire logic [31:0] i_periph_evt,
   input wire logic i_ext_pin,
   // core status
   input wire logic i_insn_end,
   input wire logic i_sleeping,
   input wire logic i_return_from_isr,
   input wire logic [irq_ctrl_pkg::PC_W-1:0] i_pc,
   // context to save
   input wire logic [7:0] i_ctx_w,
   input wire logic [7:0] i_ctx_status,
   input wire logic [4:0] i_ctx_bank,
   input wire logic [15:0] i_ctx_fsr0,
   input wire logic [15:0] i_ctx_fsr1,
   input wire logic [6:0] i_ctx_pc_latch_high,
   // control to the core
   output logic o_irq_req,
   output logic o_wake,
   output logic o_flush,
   output logic o_push_pc,
   output logic [irq_ctrl_pkg::PC_W-1:0] o_push_addr,
   output logic o_load_vector,
   output logic o_restore,
   // shadow copies
   output logic [7:0] o_shd_w,
   output logic [7:0] o_shd_status,
   output logic [4:0] o_shd_bank,
   output logic [15:0] o_shd_fsr0,
   output logic [15:0] o_shd_fsr1,
   output logic [6:0] o_shd_pc_latch_high
);
   import irq_ctrl_pkg::*;

   // whole controller state
   typedef struct packed {
      state_t state; // entry sequencer
      logic global_irq_enable; // global_irq_enable
      logic peripheral_group_enable; // peripheral_group_enable
      logic tmr0_en; // timer overflow enable
      logic ext_en; // external pin enable
      logic ioc_en; // change enable
      logic tmr0_flag; // timer overflow flag
      logic ext_flag; // ext_pin_irq_flag
      logic [31:0] pie; // peripheral_enable_regs, four lanes
      logic [31:0] pir; // peripheral_flags_one..four
      logic edge_rise; // ext_edge_select
      logic irq_req; // registered request
      logic wake; // wake pulse
      logic flush; // flush pulse
      logic push; // push pulse
      logic [PC_W-1:0] push_addr; // address pushed
      logic load_vec; // vector load pulse
      logic restore; // pop and restore pulse
      logic [7:0] shd_w; // shadow working register
      logic [7:0] shd_status; // shadow status
      logic [4:0] shd_bank; // shadow bank_select
      logic [15:0] shd_fsr0; // shadow file_select_pointer 0
      logic [15:0] shd_fsr1; // shadow file_select_pointer 1
      logic [6:0] shd_pc_latch_high; // shadow pc_latch_high
      logic pready; // bus answer
      logic pslverr; // bus error
      logic [31:0] prdata; // read data
   } ctrl_state_t;

   ctrl_state_t q;
   ctrl_state_t d;

   ext_edge_if edge_bus ();

   logic core_hit; // core sources flagged and enabled
   logic periph_hit; // peripheral sources gated by group
   logic any_src; // any source request, ignoring global
   logic take_irq; // entry taken this cycle
   logic wr_en; // apb write completes this edge
   logic addr_ok; // address decodes to a register
   logic [7:0] rd_byte; // selected register value

   // byte lane k of a 32-bit lane vector
   function automatic logic [7:0] lane(input logic [31:0] v,
                                      input logic [1:0] k);
      lane = v[{k, 3'b000} +: 8];
   endfunction

   // replace byte lane k with masked new bits
   function automatic logic [31:0] put_lane(input logic [31:0] v,
                                           input logic [1:0] k,
                                           input logic [7:0] b);
      logic [31:0] r;
      r = v;
      r[{k, 3'b000} +: 8] = b & lane(PERIPH_MASK, k);
      put_lane = r;
   endfunction

   // external pin synchroniser and edge detector
   ext_pin_edge u_ext_edge (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_ext_pin(i_ext_pin),
      .edge_bus(edge_bus.detector)
   );

   assign edge_bus.rise_sel = q.edge_rise;

   // next state
   always_comb begin
      d = q;
      // pulses fall by default
      d.wake = 1'b0;
      d.flush = 1'b0;
      d.push = 1'b0;
      d.load_vec = 1'b0;
      d.restore = 1'b0;
      // source gating
      core_hit = (q.tmr0_en & q.tmr0_flag) | (q.ext_en & q.ext_flag)
               | (q.ioc_en & i_ioc_level);
      periph_hit = q.peripheral_group_enable & (|(q.pie & q.pir));
      any_src = core_hit | periph_hit;
      d.irq_req = q.global_irq_enable & any_src;
      // address decode and read mux
      addr_ok = 1'b1;
      case (i_paddr)
         ADDR_CTRL: begin
            rd_byte = {q.global_irq_enable, q.peripheral_group_enable, q.tmr0_en, q.ext_en, q.ioc_en,
                       q.tmr0_flag, q.ext_flag, i_ioc_level};
         end
         ADDR_PIE1: rd_byte = lane(q.pie, 2'd0);
         ADDR_PIE2: rd_byte = lane(q.pie, 2'd1);
         ADDR_PIE3: rd_byte = lane(q.pie, 2'd2);
         ADDR_PIE4: rd_byte = lane(q.pie, 2'd3);
         ADDR_PERIPHERAL_FLAGS_ONE: rd_byte = lane(q.pir, 2'd0);
         ADDR_PERIPHERAL_FLAGS_TWO: rd_byte = lane(q.pir, 2'd1);
         ADDR_PERIPHERAL_FLAGS_THREE: rd_byte = lane(q.pir, 2'd2);
         ADDR_PERIPHERAL_FLAGS_FOUR: rd_byte = lane(q.pir, 2'd3);
         ADDR_OPTION: begin
            rd_byte = 8'h00;
            rd_byte[OPT_EDGE_BIT] = q.edge_rise;
         end
         ADDR_STATE: begin
            // live controller state for software
            rd_byte = {5'h00, q.irq_req, q.state == ST_ISR,
                       q.state == ST_FLUSH};
         end
         default: begin
            rd_byte = 8'h00;
            addr_ok = 1'b0;
         end
      endcase
      // apb: one wait state, answer registered
      if (i_psel && i_penable && !q.pready) begin
         d.pready = 1'b1;
         d.pslverr = ~addr_ok;
         d.prdata = i_pwrite ? 32'h00000000 : {24'h000000, rd_byte};
      end else begin
         d.pready = 1'b0;
         d.pslverr = 1'b0;
      end
      wr_en = i_psel & i_penable & i_pwrite & q.pready & addr_ok;
      // software writes
      if (wr_en) begin
         case (i_paddr)
            ADDR_CTRL: begin
               d.global_irq_enable = i_pwdata[CTRL_GIE_BIT];
               d.peripheral_group_enable = i_pwdata[CTRL_PERIPHERAL_GROUP_ENABLE_BIT];
               d.tmr0_en = i_pwdata[CTRL_TMR0_EN_BIT];
               d.ext_en = i_pwdata[CTRL_EXT_EN_BIT];
               d.ioc_en = i_pwdata[CTRL_IOC_EN_BIT];
               d.tmr0_flag = i_pwdata[CTRL_TMR0_FLAG_BIT];
               d.ext_flag = i_pwdata[CTRL_EXT_FLAG_BIT];
            end
            ADDR_PIE1: d.pie = put_lane(q.pie, 2'd0, i_pwdata[7:0]);
            ADDR_PIE2: d.pie = put_lane(q.pie, 2'd1, i_pwdata[7:0]);
            ADDR_PIE3: d.pie = put_lane(q.pie, 2'd2, i_pwdata[7:0]);
            ADDR_PIE4: d.pie = put_lane(q.pie, 2'd3, i_pwdata[7:0]);
            ADDR_PERIPHERAL_FLAGS_ONE: d.pir = put_lane(q.pir, 2'd0, i_pwdata[7:0]);
            ADDR_PERIPHERAL_FLAGS_TWO: d.pir = put_lane(q.pir, 2'd1, i_pwdata[7:0]);
            ADDR_PERIPHERAL_FLAGS_THREE: d.pir = put_lane(q.pir, 2'd2, i_pwdata[7:0]);
            ADDR_PERIPHERAL_FLAGS_FOUR: d.pir = put_lane(q.pir, 2'd3, i_pwdata[7:0]);
            ADDR_OPTION: d.edge_rise = i_pwdata[OPT_EDGE_BIT];
            default: begin
               // read-only or unmapped: nothing stored
            end
         endcase
      end
      // hardware sets after the write so a set beats a clear
      d.tmr0_flag = d.tmr0_flag | i_tmr0_evt;
      d.ext_flag = d.ext_flag | edge_bus.edge_seen;
      d.pir = d.pir | (i_periph_evt & PERIPH_MASK);
      // wake ignores global enable; firmware armed the source
      d.wake = i_sleeping & any_src & ~q.wake;
      // entry at an instruction boundary, never while asleep
      take_irq = q.global_irq_enable & any_src & i_insn_end & ~i_sleeping
               & ~i_return_from_isr & (q.state != ST_FLUSH);
      // entry sequencer
      case (q.state)
         ST_FLUSH: begin
            // second cycle of entry: point the core at the vector
            d.load_vec = 1'b1;
            d.state = ST_ISR;
         end
         ST_RUN, ST_ISR: begin
            if (i_return_from_isr) begin
               // pop, restore shadows, re-enable
               d.restore = 1'b1;
               d.global_irq_enable = 1'b1;
               d.state = ST_RUN;
            end else if (take_irq) begin
               d.state = ST_FLUSH;
               d.flush = 1'b1;
               d.global_irq_enable = 1'b0;
               d.push = 1'b1;
               d.push_addr = i_pc;
               // context copy without timeout and power-down
               d.shd_w = i_ctx_w;
               d.shd_status = i_ctx_status;
               d.shd_status[STAT_TO_BIT] = 1'b0;
               d.shd_status[STAT_PD_BIT] = 1'b0;
               d.shd_bank = i_ctx_bank;
               d.shd_fsr0 = i_ctx_fsr0;
               d.shd_fsr1 = i_ctx_fsr1;
               d.shd_pc_latch_high = i_ctx_pc_latch_high;
            end
         end
         default: begin
            d.state = ST_RUN;
         end
      endcase
   end

   // state register; every reset clears all enables
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= '0;
         q.state <= ST_RUN;
         {q.global_irq_enable, q.peripheral_group_enable, q.tmr0_en, q.ext_en, q.ioc_en, q.tmr0_flag,
          q.ext_flag} <= CTRL_RST[7:1];
         q.pie <= PIE_RST;
         q.pir <= PIR_RST;
         q.edge_rise <= EDGE_RST;
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state register
   assign o_prdata = q.prdata;
   assign o_pready = q.pready;
   assign o_pslverr = q.pslverr;
   assign o_irq_req = q.irq_req;
   assign o_wake = q.wake;
   assign o_flush = q.flush;
   assign o_push_pc = q.push;
   assign o_push_addr = q.push_addr;
   assign o_load_vector = q.load_vec;
   assign o_restore = q.restore;
   assign o_shd_w = q.shd_w;
   assign o_shd_status = q.shd_status;
   assign o_shd_bank = q.shd_bank;
   assign o_shd_fsr0 = q.shd_fsr0;
   assign o_shd_fsr1 = q.shd_fsr1;
   assign o_shd_pc_latch_high = q.shd_pc_latch_high;

   // checks
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);

   // global, group and peripheral enables are clear at the first edge after reset
   property p_reset_clear;
      $fell(i_rst) |-> !q.global_irq_enable && !q.peripheral_group_enable && q.pie == 32'h00000000;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("enables not clear after reset");

   // a flush only follows an edge where global enable was set
   property p_needs_gie;
      o_flush |-> $past(q.global_irq_enable);
   endproperty
   a_needs_gie: assert property (p_needs_gie)
      else $error("entry without global enable");

   // peripheral flags alone never enter without the group enable
   property p_group_gate;
      (!q.peripheral_group_enable && !core_hit && q.state == ST_RUN) |=> !o_flush;
   endproperty
   a_group_gate: assert property (p_group_gate)
      else $error("peripheral entry without group enable");

   // an event sets its flag whatever the enables
   property p_flag_sets;
      (i_periph_evt[0] || i_tmr0_evt) |=> q.pir[0] || q.tmr0_flag;
   endproperty
   a_flag_sets: assert property (p_flag_sets)
      else $error("event did not set its flag");

   // entry: flush with global cleared, then vector load
   property p_entry_seq;
      o_flush |-> !q.global_irq_enable && o_push_pc ##1 o_load_vector && !o_flush;
   endproperty
   a_entry_seq: assert property (p_entry_seq)
      else $error("entry sequence broken");

   // no second entry while in service with global clear
   property p_no_reentry;
      (q.state == ST_ISR && !q.global_irq_enable) |=> !o_flush;
   endproperty
   a_no_reentry: assert property (p_no_reentry)
      else $error("re-entered with global enable clear");

   // return restores and re-enables on the next edge
   property p_return;
      (i_return_from_isr && q.state != ST_FLUSH) |=> o_restore && q.global_irq_enable;
   endproperty
   a_return: assert property (p_return)
      else $error("return did not restore");

   // timer event to vector load in three cycles
   property p_latency;
      (i_tmr0_evt && q.global_irq_enable && q.tmr0_en && q.state == ST_RUN
       && !i_return_from_isr && !i_sleeping)
      ##1 (i_insn_end && !i_return_from_isr && !i_sleeping)
      |-> ##1 o_flush ##1 o_load_vector;
   endproperty
   a_latency: assert property (p_latency)
      else $error("latency not three cycles");

   // detected pin edge sets the pin flag
   property p_pin_flag;
      edge_bus.edge_seen |=> q.ext_flag;
   endproperty
   a_pin_flag: assert property (p_pin_flag)
      else $error("pin edge not flagged");

   // nothing enters while the core sleeps
   property p_sleep_first;
      i_sleeping |=> !o_flush;
   endproperty
   a_sleep_first: assert property (p_sleep_first)
      else $error("entry while asleep");

   // request only with global enable
   property p_req_gie;
      o_irq_req |-> $past(q.global_irq_enable) && $past(any_src);
   endproperty
   a_req_gie: assert property (p_req_gie)
      else $error("request without global enable");
endmodule
`default_nettype wire

// *** src/irq_ctrl_pkg.sv ***
`default_nettype none
package irq_ctrl_pkg;
   // bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int PC_W = 15;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PIE1 = 8'h04;
   localparam logic [7:0] ADDR_PIE2 = 8'h08;
   localparam logic [7:0] ADDR_PIE3 = 8'h0C;
   localparam logic [7:0] ADDR_PIE4 = 8'h10;
   localparam logic [7:0] ADDR_PERIPHERAL_FLAGS_ONE = 8'h14;
   localparam logic [7:0] ADDR_PERIPHERAL_FLAGS_TWO = 8'h18;
   localparam logic [7:0] ADDR_PERIPHERAL_FLAGS_THREE = 8'h1C;
   localparam logic [7:0] ADDR_PERIPHERAL_FLAGS_FOUR = 8'h20;
   localparam logic [7:0] ADDR_OPTION = 8'h24;
   localparam logic [7:0] ADDR_STATE = 8'h28;
   // core_irq_control field positions
   localparam int CTRL_GIE_BIT = 7;
   localparam int CTRL_PERIPHERAL_GROUP_ENABLE_BIT = 6;
   localparam int CTRL_TMR0_EN_BIT = 5;
   localparam int CTRL_EXT_EN_BIT = 4;
   localparam int CTRL_IOC_EN_BIT = 3;
   localparam int CTRL_TMR0_FLAG_BIT = 2;
   localparam int CTRL_EXT_FLAG_BIT = 1;
   localparam int CTRL_IOC_FLAG_BIT = 0;
   // option register: edge select position
   localparam int OPT_EDGE_BIT = 6;
   // status bits excluded from the context copy
   localparam int STAT_TO_BIT = 4;
   localparam int STAT_PD_BIT = 3;
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [31:0] PIE_RST = 32'h00000000;
   localparam logic [31:0] PIR_RST = 32'h00000000;
   localparam logic EDGE_RST = 1'b0;
   // implemented bits of the four peripheral byte lanes (4..1)
   localparam logic [31:0] PERIPH_MASK = 32'h033AF9FF;
   // interrupt vector address
   localparam logic [PC_W-1:0] VECTOR_ADDR = 15'h0004;
   // entry sequencer states
   typedef enum logic [1:0] {ST_RUN, ST_FLUSH, ST_ISR} state_t;
endpackage
`default_nettype wire

// *** src/ext_edge_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// carries the edge choice out and the detected edge back
interface ext_edge_if;
   logic rise_sel; // high: rising edge counts
   logic edge_seen; // one-cycle pulse on a valid edge
   modport detector (input rise_sel, output edge_seen);
   modport owner (output rise_sel, input edge_seen);
endinterface
`default_nettype wire

// *** src/ext_pin_edge.sv ***
`timescale 1ns/100ps
`default_nettype none
// synchronises the external pin and flags the selected edge
module ext_pin_edge (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // raw asynchronous pin
   input wire logic i_ext_pin,
   // edge choice and result
   ext_edge_if.detector edge_bus
);
   // all detector state
   typedef struct packed {
      logic sync1; // first stage, read only by sync2
      logic sync2; // second stage
      logic prev; // sync2 one cycle back
      logic seen; // registered edge pulse
   } det_state_t;

   det_state_t q;
   det_state_t d;

   // next state: shift the pin through and compare stages
   always_comb begin
      d = q;
      d.sync1 = i_ext_pin;
      d.sync2 = q.sync1;
      d.prev = q.sync2;
      // edge polarity chosen by the owner
      if (edge_bus.rise_sel) begin
         d.seen = q.sync2 & ~q.prev;
      end else begin
         d.seen = ~q.sync2 & q.prev;
      end
   end

   // state register
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign edge_bus.edge_seen = q.seen;
endmodule
`default_nettype wire

// *** dv/core_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// stands in for the processor core: one-cycle instructions, fixed context
module core_model
   import irq_ctrl_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // redirect from the controller
   input wire logic i_load_vector,
   // firmware has executed sleep and no wake has come yet
   input wire logic i_sleep,
   // core status and context
   output logic o_insn_end,
   output logic o_sleeping,
   output logic [irq_ctrl_pkg::PC_W-1:0] o_pc,
   output logic [7:0] o_w,
   output logic [7:0] o_status,
   output logic [4:0] o_bank,
   output logic [15:0] o_fsr0,
   output logic [15:0] o_fsr1,
   output logic [6:0] o_pc_latch_high
);
   import irq_ctrl_pkg::*;
   // every instruction finishes in one cycle; sleep comes from the bench
   assign o_insn_end = !i_rst;
   assign o_sleeping = i_sleep;
   // fixed context, status all ones so the excluded bits show
   assign o_w = 8'h3C;
   assign o_status = 8'hFF;
   assign o_bank = 5'h15;
   assign o_fsr0 = 16'hA55A;
   assign o_fsr1 = 16'h1234;
   assign o_pc_latch_high = 7'h2B;
   // program counter steps, jumps to the vector on request
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pc <= 15'h0100;
      end else if (i_load_vector) begin
         o_pc <= VECTOR_ADDR;
      end else begin
         o_pc <= o_pc + 15'h0001;
      end
   end
endmodule
`default_nettype wire

// *** dv/core_interrupt_controller_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module core_interrupt_controller_tb;
   import irq_ctrl_pkg::*;
   logic clk = 1'b0, rst = 1'b1;
   logic psel = 0, pen = 0, pwr = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, tmr0 = 0, pin = 0, return_from_isr = 0, sleep = 0;
   int wakes = 0;
   logic [31:0] pevt = 32'h0;
   logic insn_end, sleeping, irq, wake, flush, push, ldv, restore;
   logic [14:0] pc, push_addr;
   logic [7:0] w, st, shd_w, shd_st;
   logic [4:0] bank;
   logic [15:0] f0, f1;
   logic [6:0] pcl;
   int fails = 0, total_checks = 0, cycles = 0, flushes = 0, restores = 0;
   logic [14:0] last_pc, push_exp, push_seen;
   logic [31:0] rd;
   logic err;
   // clock: 40 ns period
   always #20 clk = ~clk;
   core_interrupt_controller dut_u (.i_ref_clk(clk), .i_rst(rst),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_tmr0_evt(tmr0), .i_ioc_level(1'b0),
      .i_periph_evt(pevt), .i_ext_pin(pin), .i_insn_end(insn_end),
      .i_sleeping(sleeping), .i_return_from_isr(return_from_isr), .i_pc(pc), .i_ctx_w(w),
      .i_ctx_status(st), .i_ctx_bank(bank), .i_ctx_fsr0(f0),
      .i_ctx_fsr1(f1), .i_ctx_pc_latch_high(pcl), .o_irq_req(irq),
      .o_wake(wake), .o_flush(flush), .o_push_pc(push),
      .o_push_addr(push_addr), .o_load_vector(ldv), .o_restore(restore),
      .o_shd_w(shd_w), .o_shd_status(shd_st), .o_shd_bank(),
      .o_shd_fsr0(), .o_shd_fsr1(), .o_shd_pc_latch_high());
   core_model core_u (.i_ref_clk(clk), .i_rst(rst), .i_load_vector(ldv),
      .i_sleep(sleep),
      .o_insn_end(insn_end), .o_sleeping(sleeping), .o_pc(pc), .o_w(w),
      .o_status(st), .o_bank(bank), .o_fsr0(f0), .o_fsr1(f1),
      .o_pc_latch_high(pcl));
   // monitor: counts entries and returns, keeps the pushed address
   always @(posedge clk) begin
      cycles++;
      if (flush === 1'b1) begin
         flushes++;
         push_seen = push_addr;
         push_exp = last_pc;
      end
      if (restore === 1'b1) restores++;
      if (wake === 1'b1) wakes++;
      last_pc = pc;
      if (cycles > 20000) begin
         fails++;
         wrap_up();
      end
   end
   // one comparison
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1; pwr <= wr; paddr <= a; pwdata <= d; pen <= 0;
      @(posedge clk);
      pen <= 1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 0; pen <= 0;
      @(posedge clk);
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a, exp);
      apb(0, a, 0);
      chk(nm, rd, {24'h0, exp});
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // firmware return from the service routine
   task automatic do_return();
      return_from_isr <= 1;
      @(posedge clk);
      return_from_isr <= 0;
      idle(3);
   endtask
   task automatic t_reset_values();
      rdchk("ctrl", ADDR_CTRL, 8'h00);
      rdchk("pie1", ADDR_PIE1, 8'h00);
      apb(0, 8'h40, 0);
      chk("unmapped err", err, 1);
      chk("unmapped data", rd, 0);
   endtask
   task automatic t_pending_entry();
      apb(1, ADDR_CTRL, 32'h20);
      tmr0 <= 1;
      @(posedge clk);
      tmr0 <= 0;
      idle(4);
      rdchk("flag no gie", ADDR_CTRL, 8'h24);
      chk("no entry", flushes, 0);
      apb(1, ADDR_CTRL, 32'hA4);
      idle(6);
      chk("pending entry", flushes, 1);
      rdchk("gie cleared", ADDR_CTRL, 8'h24);
      chk("pushed pc", push_seen, push_exp);
      chk("shadow status", shd_st, 8'hE7);
      chk("shadow w", shd_w, 8'h3C);
      chk("vector pc", pc[14:4] == 0, 1);
      apb(1, ADDR_CTRL, 32'h20);
      do_return();
      chk("restore", restores, 1);
      rdchk("gie set", ADDR_CTRL, 8'hA0);
   endtask
   task automatic t_latency();
      int n;
      n = 0;
      tmr0 <= 1;
      @(posedge clk);
      tmr0 <= 0;
      do begin
         @(posedge clk);
         n++;
      end while (ldv !== 1'b1 && n < 20);
      chk("latency", (n >= 3) && (n <= 4), 1);
      chk("single entry", flushes, 2);
      apb(1, ADDR_CTRL, 32'h20);
      do_return();
   endtask
   task automatic t_peripheral();
      apb(1, ADDR_CTRL, 32'h80);
      apb(1, ADDR_PIE1, 32'h01);
      pevt <= 32'h1;
      @(posedge clk);
      pevt <= 32'h0;
      idle(5);
      chk("no group enable", flushes, 2);
      rdchk("periph flag", ADDR_PERIPHERAL_FLAGS_ONE, 8'h01);
      apb(1, ADDR_CTRL, 32'hC0);
      idle(6);
      chk("group entry", flushes, 3);
      apb(1, ADDR_PERIPHERAL_FLAGS_ONE, 32'h00);
      do_return();
      apb(1, ADDR_CTRL, 32'h10);
   endtask
   task automatic t_ext_pin();
      apb(1, ADDR_OPTION, 32'h40);
      pin <= 1;
      idle(6);
      rdchk("rise sel rise", ADDR_CTRL, 8'h12);
      apb(1, ADDR_CTRL, 32'h10);
      pin <= 0;
      idle(6);
      rdchk("rise sel fall", ADDR_CTRL, 8'h10);
      apb(1, ADDR_OPTION, 32'h00);
      pin <= 1;
      idle(6);
      rdchk("fall sel rise", ADDR_CTRL, 8'h10);
      pin <= 0;
      idle(6);
      rdchk("fall sel fall", ADDR_CTRL, 8'h12);
      apb(1, ADDR_CTRL, 32'h92);
      idle(6);
      chk("pin entry", flushes, 4);
   endtask
   // sleep with the timer armed, first without and then with global
   task automatic t_sleep();
      apb(1, ADDR_CTRL, 32'h20);
      sleep <= 1;
      tmr0 <= 1;
      @(posedge clk);
      tmr0 <= 0;
      idle(4);
      chk("wake pulse", wakes > 0, 1);
      chk("no entry asleep", flushes, 4);
      sleep <= 0;
      idle(4);
      chk("continue no gie", flushes, 4);
      sleep <= 1;
      apb(1, ADDR_CTRL, 32'hA4);
      idle(1);
      chk("irq request", irq, 1);
      chk("still asleep", flushes, 4);
      sleep <= 0;
      idle(4);
      chk("wake entry", flushes, 5);
   endtask
   // closing report
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      t_reset_values();
      t_pending_entry();
      t_latency();
      t_peripheral();
      t_ext_pin();
      t_sleep();
      wrap_up();
   end
endmodule
`default_nettype wire
